// [include/clkreg_pkg.sv]
// Package with register map, field layout, reset values and shared types of the bias/oscillator/output bank.
// Functional notes
// - Bit 0 of the bias status reads 0 while calibration runs and 1 once it has finished.
// - Bit 1 of the bias status reads 1 for a failed calibration and 0 for success, meaningful once done is set.
// - Bits 4:2 of the bias status show the code chosen by the calibration logic.
// - Bits 7:5 of the bias status show the code actually applied to the bias circuit.
// - Bit 8 of the bias status shows the raw comparator output.
// - Bit 16 of the oscillator control enables the oscillator regulator and resets to 1.
// - Bits 15:14 of the oscillator control pick zero to three start-up boost amplifiers and reset to 1.
// - The divider ratio sits in bits 13:0, resets to 0x69, and software must keep it at 10 or more.
// - Bit 15 of the divider control enables the divider regulator and resets to 1.
// - Disabled-state field 1 holds low/high, 2 holds both high impedance, 3 keeps toggling.
// - Disabled-state field 0 holds both low, except in LVDS mode where it holds low/high.
// - The force-disable bit at position 1 disables the driver; clear leaves it to the other enables.
// - The power-down bit at position 0 tri-states both outputs and overrides the enable control.
// - A 2-bit mode field picks HCSL, reserved, LVDS or CMOS and decides the LVDS exception.
package clkreg_pkg;

	// ------------------------------------------------------------
	// Register offsets
	// ------------------------------------------------------------
	localparam logic [7:0] ADDR_BIAS_STS  = 8'h00;
	localparam logic [7:0] ADDR_XO_CTRL   = 8'h04;
	localparam logic [7:0] ADDR_OD_CTRL   = 8'h08;
	localparam logic [7:0] ADDR_DRV_EN    = 8'h0c;
	localparam logic [7:0] ADDR_DRV_MODE  = 8'h10;

	// ------------------------------------------------------------
	// Field positions
	// ------------------------------------------------------------
	localparam int BIAS_DONE_BIT  = 0;
	localparam int BIAS_FAIL_BIT  = 1;
	localparam int BIAS_CODE_LSB  = 2;
	localparam int BIAS_EFF_LSB   = 5;
	localparam int BIAS_CMP_BIT   = 8;
	localparam int XO_SPARE_LSB   = 17;
	localparam int XO_REG_BIT     = 16;
	localparam int XO_GAIN_LSB    = 14;
	localparam int OD_REG_BIT     = 15;
	localparam int OD_RATIO_LSB   = 0;
	localparam int DRV_STATE_LSB  = 2;
	localparam int DRV_DIS_BIT    = 1;
	localparam int DRV_PD_BIT     = 0;
	localparam int MODE_LSB       = 0;

	// ------------------------------------------------------------
	// Reset values and limits
	// ------------------------------------------------------------
	localparam logic [13:0] XO_LOW_RST    = 14'h1f1f;
	localparam logic [1:0]  XO_GAIN_RST   = 2'h1;
	localparam logic        XO_REG_RST    = 1'h1;
	localparam logic [13:0] OD_RATIO_RST  = 14'h0069;
	localparam logic [13:0] OD_RATIO_MIN  = 14'h000a;
	localparam logic        OD_REG_RST    = 1'h1;
	localparam logic [1:0]  MODE_HCSL     = 2'h0;
	localparam logic [1:0]  MODE_LVDS     = 2'h2;
	localparam logic [1:0]  MODE_CMOS     = 2'h3;
	localparam logic [1:0]  DIS_LOW_LOW   = 2'h0;
	localparam logic [1:0]  DIS_LOW_HIGH  = 2'h1;
	localparam logic [1:0]  DIS_HIZ       = 2'h2;
	localparam logic [1:0]  DIS_TOGGLE    = 2'h3;

	typedef enum logic [1:0] {
		ACC_IDLE,
		ACC_READ,
		ACC_WRITE
	} acc_e;

	typedef struct packed {
		logic        done;
		logic        fail;
		logic [2:0]  code;
		logic [2:0]  eff;
		logic        cmp;
	} bias_s;

	typedef struct packed {
		logic        oe;
		logic        t;
		logic        c;
	} pair_s;

	typedef struct packed {
		pair_s       pin_true;
		pair_s       pin_comp;
		logic        powered;
	} drv_out_s;

endpackage : clkreg_pkg

// [logic/out_pair_ctrl.sv]
// Output pair driver: applies power-down, disable and disabled-state choices to one clock pair.
`timescale 1ns/1ps
module out_pair_ctrl
	import clkreg_pkg::*;
(
	input  wire logic [1:0] mode,
	input  wire logic [1:0] dis_state,
	input  wire logic       force_dis,
	input  wire logic       pwr_down,
	input  wire logic       oe_pin,
	input  wire logic       clk_in,
	output drv_out_s        drv
);

	logic enabled;

	always_comb begin
		enabled = oe_pin & ~force_dis;
		drv.powered = ~pwr_down;
		drv.pin_true = '{oe: 1'b1, t: clk_in, c: 1'b0};
		drv.pin_comp = '{oe: 1'b1, t: 1'b0, c: 1'b0};
		if (mode == MODE_CMOS) begin
			drv.pin_comp.t = clk_in;
		end else begin
			drv.pin_comp.t = ~clk_in;
		end
		if (pwr_down) begin
			drv.pin_true.oe = 1'b0;
			drv.pin_comp.oe = 1'b0;
		end else if (!enabled) begin
			case (dis_state)
				DIS_LOW_LOW: begin
					drv.pin_true.t = 1'b0;
					drv.pin_comp.t = (mode == MODE_LVDS);
				end
				DIS_LOW_HIGH: begin
					drv.pin_true.t = 1'b0;
					drv.pin_comp.t = 1'b1;
				end
				DIS_HIZ: begin
					drv.pin_true.oe = 1'b0;
					drv.pin_comp.oe = 1'b0;
				end
				default: begin
				end
			endcase
		end
	end

endmodule : out_pair_ctrl

// [logic/clk_ctrl_regs.sv]
// Register bank for bias status, crystal oscillator control and one output divider/driver pair.
`timescale 1ns/1ps
module clk_ctrl_regs
	import clkreg_pkg::*;
(
	input  wire logic        clk,
	input  wire logic        rstn,
	input  wire logic        ce,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	input  wire logic [7:0]  reg_addr,
	input  wire logic [31:0] reg_wdata,
	output logic      [31:0] reg_rdata,
	input  wire logic        cal_done_in,
	input  wire logic        cal_fail_in,
	input  wire logic [2:0]  cal_code_in,
	input  wire logic [2:0]  cal_eff_in,
	input  wire logic        cal_cmp_in,
	input  wire logic        oe_in,
	input  wire logic        div_clk_in,
	output logic             oscillator_regulator_on,
	output logic [1:0]       boost_amp_sel,
	output logic [1:0]       oscillator_spare_bits,
	output logic [13:0]      oscillator_trim_bits,
	output logic             divider_regulator_on,
	output logic [13:0]      divider_ratio,
	output logic             driver_power_down,
	output logic             clock_output_true_o,
	output logic             clock_output_true_oe,
	output logic             clock_output_complement_o,
	output logic             clock_output_complement_oe
);

	// ------------------------------------------------------------
	// State
	// ------------------------------------------------------------
	typedef struct packed {
		bias_s       bias_s1;
		bias_s       bias_s2;
		bias_s       bias_s3;
		bias_s       bias_hold;
		logic        oe_s1;
		logic        oe_s2;
		logic        clk_s1;
		logic        clk_s2;
		logic        xo_reg;
		logic [1:0]  xo_gain;
		logic [1:0]  xo_spare;
		logic [13:0] xo_low;
		logic        od_reg;
		logic [13:0] od_ratio;
		logic [1:0]  dis_state;
		logic        force_dis;
		logic        pwr_down;
		logic [1:0]  mode;
		logic [31:0] rdata;
		drv_out_s    drv;
	} state_s;

	state_s   st_q;
	state_s   st_d;
	drv_out_s drv_next;
	acc_e     acc;

	out_pair_ctrl u_pair (
		.mode      (st_q.mode),
		.dis_state (st_q.dis_state),
		.force_dis (st_q.force_dis),
		.pwr_down  (st_q.pwr_down),
		.oe_pin    (st_q.oe_s2),
		.clk_in    (st_q.clk_s2),
		.drv       (drv_next)
	);

	// ------------------------------------------------------------
	// Next state
	// ------------------------------------------------------------
	always_comb begin
		st_d = st_q;
		acc = reg_wr ? ACC_WRITE : (reg_rd ? ACC_READ : ACC_IDLE);
		st_d.bias_s1 = '{done: cal_done_in, fail: cal_fail_in, code: cal_code_in, eff: cal_eff_in, cmp: cal_cmp_in};
		st_d.bias_s2 = st_q.bias_s1;
		st_d.bias_s3 = st_q.bias_s2;
		// The status word is taken only when two synced samples agree, so a torn code is never shown.
		// The raw comparator bit is left out of the match because it may toggle freely.
		if (st_q.bias_s3[8:1] == st_q.bias_s2[8:1]) begin
			st_d.bias_hold = st_q.bias_s2;
		end
		st_d.oe_s1 = oe_in;
		st_d.oe_s2 = st_q.oe_s1;
		st_d.clk_s1 = div_clk_in;
		st_d.clk_s2 = st_q.clk_s1;
		st_d.drv = drv_next;
		case (acc)
			ACC_WRITE: begin
				case (reg_addr)
					ADDR_XO_CTRL: begin
						st_d.xo_spare = reg_wdata[XO_SPARE_LSB +: 2];
						st_d.xo_reg = reg_wdata[XO_REG_BIT];
						st_d.xo_gain = reg_wdata[XO_GAIN_LSB +: 2];
						st_d.xo_low = reg_wdata[13:0];
					end
					ADDR_OD_CTRL: begin
						st_d.od_reg = reg_wdata[OD_REG_BIT];
						st_d.od_ratio = reg_wdata[OD_RATIO_LSB +: 14];
					end
					ADDR_DRV_EN: begin
						st_d.dis_state = reg_wdata[DRV_STATE_LSB +: 2];
						st_d.force_dis = reg_wdata[DRV_DIS_BIT];
						st_d.pwr_down = reg_wdata[DRV_PD_BIT];
					end
					ADDR_DRV_MODE: begin
						st_d.mode = reg_wdata[MODE_LSB +: 2];
					end
					default: begin
					end
				endcase
			end
			ACC_READ: begin
				st_d.rdata = 32'h0000_0000;
				case (reg_addr)
					ADDR_BIAS_STS: begin
						st_d.rdata[BIAS_DONE_BIT] = st_q.bias_hold.done;
						st_d.rdata[BIAS_FAIL_BIT] = st_q.bias_hold.fail;
						st_d.rdata[BIAS_CODE_LSB +: 3] = st_q.bias_hold.code;
						st_d.rdata[BIAS_EFF_LSB +: 3] = st_q.bias_hold.eff;
						st_d.rdata[BIAS_CMP_BIT] = st_q.bias_s2.cmp;
					end
					ADDR_XO_CTRL: begin
						st_d.rdata[XO_SPARE_LSB +: 2] = st_q.xo_spare;
						st_d.rdata[XO_REG_BIT] = st_q.xo_reg;
						st_d.rdata[XO_GAIN_LSB +: 2] = st_q.xo_gain;
						st_d.rdata[13:0] = st_q.xo_low;
					end
					ADDR_OD_CTRL: begin
						st_d.rdata[OD_REG_BIT] = st_q.od_reg;
						st_d.rdata[OD_RATIO_LSB +: 14] = st_q.od_ratio;
					end
					ADDR_DRV_EN: begin
						st_d.rdata[DRV_STATE_LSB +: 2] = st_q.dis_state;
						st_d.rdata[DRV_DIS_BIT] = st_q.force_dis;
						st_d.rdata[DRV_PD_BIT] = st_q.pwr_down;
					end
					ADDR_DRV_MODE: begin
						st_d.rdata[MODE_LSB +: 2] = st_q.mode;
					end
					default: begin
					end
				endcase
			end
			default: begin
			end
		endcase
	end

	// ------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------
	always_ff @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			st_q <= '0;
			st_q.xo_reg <= XO_REG_RST;
			st_q.xo_gain <= XO_GAIN_RST;
			st_q.xo_low <= XO_LOW_RST;
			st_q.od_reg <= OD_REG_RST;
			st_q.od_ratio <= OD_RATIO_RST;
			st_q.mode <= MODE_HCSL;
		end else if (ce) begin
			st_q <= st_d;
		end
	end

	assign reg_rdata = st_q.rdata;
	assign oscillator_regulator_on = st_q.xo_reg;
	assign boost_amp_sel = st_q.xo_gain;
	assign oscillator_spare_bits = st_q.xo_spare;
	assign oscillator_trim_bits = st_q.xo_low;
	assign divider_regulator_on = st_q.od_reg;
	assign divider_ratio = st_q.od_ratio;
	assign driver_power_down = st_q.pwr_down;
	assign clock_output_true_o = st_q.drv.pin_true.t;
	assign clock_output_true_oe = st_q.drv.pin_true.oe;
	assign clock_output_complement_o = st_q.drv.pin_comp.t;
	assign clock_output_complement_oe = st_q.drv.pin_comp.oe;

endmodule : clk_ctrl_regs

// [testbench/clk_ctrl_regs_asserts.sv]
// Checker for register writes, readback and power-down on the register bank ports.
`timescale 1ns/1ps
module clk_ctrl_regs_asserts
	import clkreg_pkg::*;
(
	input wire logic        clk,
	input wire logic        rstn,
	input wire logic        ce,
	input wire logic        reg_wr,
	input wire logic        reg_rd,
	input wire logic [7:0]  reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic [31:0] reg_rdata,
	input wire logic        oscillator_regulator_on,
	input wire logic [1:0]  boost_amp_sel,
	input wire logic [1:0]  oscillator_spare_bits,
	input wire logic [13:0] oscillator_trim_bits,
	input wire logic        divider_regulator_on,
	input wire logic [13:0] divider_ratio,
	input wire logic        driver_power_down,
	input wire logic        clock_output_true_oe,
	input wire logic        clock_output_complement_oe
);
	wire logic        wr_take = ce && reg_wr;
	wire logic        rd_take = ce && reg_rd && !reg_wr;
	wire logic [18:0] xo_v    = {oscillator_spare_bits, oscillator_regulator_on, boost_amp_sel, oscillator_trim_bits};
	wire logic [15:0] od_v    = {divider_regulator_on, 1'h0, divider_ratio};

	default clocking cb @(posedge clk); endclocking
	default disable iff (!rstn);

	xo_write_a: assert property (wr_take && reg_addr == ADDR_XO_CTRL |=> xo_v == $past(reg_wdata[18:0]))
		else $error("oscillator control write not applied");
	div_write_a: assert property (wr_take && reg_addr == ADDR_OD_CTRL |=> od_v == ($past(reg_wdata[15:0]) & 16'hbfff))
		else $error("divider control write not applied");
	pd_write_a: assert property (wr_take && reg_addr == ADDR_DRV_EN |=> driver_power_down == $past(reg_wdata[0]))
		else $error("power-down bit write not applied");
	cfg_hold_a: assert property (!wr_take || reg_addr == ADDR_BIAS_STS |=> $stable({xo_v, od_v, driver_power_down}))
		else $error("configuration changed without a write");
	pd_tristate_a: assert property (ce && driver_power_down |=> !clock_output_true_oe && !clock_output_complement_oe)
		else $error("outputs driven while powered down");
	bias_read_a: assert property (rd_take && reg_addr == ADDR_BIAS_STS |=> reg_rdata[31:9] == 23'h0)
		else $error("bias status reserved bits not zero");
	xo_read_a: assert property (rd_take && reg_addr == ADDR_XO_CTRL |=> reg_rdata == {13'h0, $past(xo_v)})
		else $error("oscillator control readback wrong");
	div_read_a: assert property (rd_take && reg_addr == ADDR_OD_CTRL |=> reg_rdata == {16'h0, $past(od_v)})
		else $error("divider control readback wrong");
endmodule : clk_ctrl_regs_asserts

bind clk_ctrl_regs clk_ctrl_regs_asserts i_clk_ctrl_regs_asserts (
	.clk                        (clk),
	.rstn                       (rstn),
	.ce                         (ce),
	.reg_wr                     (reg_wr),
	.reg_rd                     (reg_rd),
	.reg_addr                   (reg_addr),
	.reg_wdata                  (reg_wdata),
	.reg_rdata                  (reg_rdata),
	.oscillator_regulator_on    (oscillator_regulator_on),
	.boost_amp_sel              (boost_amp_sel),
	.oscillator_spare_bits      (oscillator_spare_bits),
	.oscillator_trim_bits       (oscillator_trim_bits),
	.divider_regulator_on       (divider_regulator_on),
	.divider_ratio              (divider_ratio),
	.driver_power_down          (driver_power_down),
	.clock_output_true_oe       (clock_output_true_oe),
	.clock_output_complement_oe (clock_output_complement_oe)
);

// [testbench/testbench.sv]
// Self-checking testbench for the register bank and its output pair.
`timescale 1ns/1ps
module testbench import clkreg_pkg::*;;
	logic        clk = 1'h0, rstn = 1'h0, ce = 1'h1, reg_wr = 1'h0, reg_rd = 1'h0;
	logic [7:0]  reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0, reg_rdata;
	logic        cal_done_in = 1'h0, cal_fail_in = 1'h0, cal_cmp_in = 1'h0, oe_in = 1'h1, div_clk_in = 1'h1;
	logic [2:0]  cal_code_in = 3'h0, cal_eff_in = 3'h0;
	logic        oscillator_regulator_on, divider_regulator_on, driver_power_down;
	logic        clock_output_true_o, clock_output_true_oe, clock_output_complement_o, clock_output_complement_oe;
	logic [1:0]  boost_amp_sel, oscillator_spare_bits;
	logic [13:0] oscillator_trim_bits, divider_ratio;
	int          failures = 0, cmp_count = 0;

	clk_ctrl_regs i_clk_ctrl_regs (
		.clk                        (clk),
		.rstn                       (rstn),
		.ce                         (ce),
		.reg_wr                     (reg_wr),
		.reg_rd                     (reg_rd),
		.reg_addr                   (reg_addr),
		.reg_wdata                  (reg_wdata),
		.reg_rdata                  (reg_rdata),
		.cal_done_in                (cal_done_in),
		.cal_fail_in                (cal_fail_in),
		.cal_code_in                (cal_code_in),
		.cal_eff_in                 (cal_eff_in),
		.cal_cmp_in                 (cal_cmp_in),
		.oe_in                      (oe_in),
		.div_clk_in                 (div_clk_in),
		.oscillator_regulator_on    (oscillator_regulator_on),
		.boost_amp_sel              (boost_amp_sel),
		.oscillator_spare_bits      (oscillator_spare_bits),
		.oscillator_trim_bits       (oscillator_trim_bits),
		.divider_regulator_on       (divider_regulator_on),
		.divider_ratio              (divider_ratio),
		.driver_power_down          (driver_power_down),
		.clock_output_true_o        (clock_output_true_o),
		.clock_output_true_oe       (clock_output_true_oe),
		.clock_output_complement_o  (clock_output_complement_o),
		.clock_output_complement_oe (clock_output_complement_oe)
	);

	always #4 clk = ~clk;

	// ------------------------------------------------------------
	// Access tasks
	// ------------------------------------------------------------
	task automatic chk(input string name, input logic [31:0] exp, input logic [31:0] got);
		cmp_count++;
		if (got !== exp) begin
			failures++;
			$display("CHECK FAILED %s expected %h seen %h", name, exp, got);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [31:0] exp);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
		@(posedge clk);
		chk("reg_rdata", exp, reg_rdata);
	endtask : rd

	// Expected pattern is {true oe, true level, complement oe, complement level}, levels masked by oe.
	task automatic pins(input logic [1:0] m, input logic [7:0] en, input logic o, input logic [3:0] exp);
		wr(ADDR_DRV_MODE, {30'h0, m});
		wr(ADDR_DRV_EN, {24'h0, en});
		oe_in <= o;
		repeat (6) @(posedge clk);
		chk("pair", {28'h0, exp}, {28'h0, clock_output_true_oe, clock_output_true_o & clock_output_true_oe,
			clock_output_complement_oe, clock_output_complement_o & clock_output_complement_oe});
	endtask : pins

	task automatic report_and_stop;
		$display("comparisons %0d mismatches %0d", cmp_count, failures);
		if (failures == 0 && cmp_count > 0) begin
			$display("Testbench passed");
		end else begin
			$display("Testbench failed");
		end
		$finish;
	endtask : report_and_stop

	// ------------------------------------------------------------
	// Tests
	// ------------------------------------------------------------
	initial begin
		repeat (10) @(posedge clk);
		rstn <= 1'h1;
		rd(ADDR_BIAS_STS, 32'h0);
		rd(ADDR_XO_CTRL, 32'h00015f1f);
		rd(ADDR_OD_CTRL, 32'h00008069);
		rd(ADDR_DRV_EN, 32'h0);
		rd(ADDR_DRV_MODE, 32'h0);
		rd(8'h20, 32'h0);
		$display("test reset values done");
		cal_done_in <= 1'h1;
		cal_code_in <= 3'h5;
		cal_eff_in <= 3'h2;
		cal_cmp_in <= 1'h1;
		repeat (3) @(posedge clk);
		rd(ADDR_BIAS_STS, 32'h155);
		cal_done_in <= 1'h0;
		cal_fail_in <= 1'h1;
		cal_code_in <= 3'h3;
		cal_eff_in <= 3'h6;
		cal_cmp_in <= 1'h0;
		wr(ADDR_BIAS_STS, 32'hffffffff);
		repeat (2) @(posedge clk);
		rd(ADDR_BIAS_STS, 32'h0ce);
		$display("test bias status done");
		wr(ADDR_XO_CTRL, 32'hffffffff);
		rd(ADDR_XO_CTRL, 32'h0007ffff);
		for (int g = 0; g < 4; g++) begin
			wr(ADDR_XO_CTRL, {16'h0, g[1:0], 14'h0});
			@(posedge clk);
			chk("boost_amp_sel", {30'h0, g[1:0]}, {30'h0, boost_amp_sel});
		end
		wr(ADDR_OD_CTRL, 32'hffffffff);
		rd(ADDR_OD_CTRL, 32'h0000bfff);
		wr(ADDR_OD_CTRL, 32'h0000000a);
		rd(ADDR_OD_CTRL, 32'h0000000a);
		ce <= 1'h0;
		wr(ADDR_OD_CTRL, 32'h00008123);
		ce <= 1'h1;
		rd(ADDR_OD_CTRL, 32'h0000000a);
		wr(ADDR_DRV_EN, 32'h000000ff);
		rd(ADDR_DRV_EN, 32'h0000000f);
		wr(ADDR_DRV_MODE, 32'hffffffff);
		rd(ADDR_DRV_MODE, 32'h00000003);
		$display("test register writes done");
		pins(2'h0, 8'h00, 1'h1, 4'he);
		pins(2'h0, 8'h02, 1'h1, 4'ha);
		pins(2'h0, 8'h06, 1'h1, 4'hb);
		pins(2'h0, 8'h0a, 1'h1, 4'h0);
		pins(2'h0, 8'h0e, 1'h1, 4'he);
		pins(2'h2, 8'h02, 1'h1, 4'hb);
		pins(2'h2, 8'h00, 1'h1, 4'he);
		pins(2'h3, 8'h00, 1'h1, 4'hf);
		pins(2'h3, 8'h02, 1'h1, 4'ha);
		div_clk_in <= 1'h0;
		pins(2'h0, 8'h00, 1'h1, 4'hb);
		pins(2'h3, 8'h00, 1'h1, 4'ha);
		div_clk_in <= 1'h1;
		pins(2'h0, 8'h04, 1'h0, 4'hb);
		pins(2'h0, 8'h01, 1'h1, 4'h0);
		pins(2'h0, 8'h05, 1'h0, 4'h0);
		$display("test output pair done");
		report_and_stop;
	end

	initial begin
		repeat (5000) @(posedge clk);
		failures++;
		report_and_stop;
	end
endmodule : testbench
